// ---- port_io_pkg.sv ----
// port_io_pkg: register addresses, pages, reset values and field positions
// for the three-port i/o block with port match.
// assumes an 8-bit special function register bus with a page number.
package port_io_pkg;

  // register pages
  localparam logic [3:0] PAGE_MAIN = 4'h0;
  localparam logic [3:0] PAGE_ALT = 4'hF;

  // port data registers, decoded on every page
  localparam logic [7:0] ADDR_PORT_ZERO = 8'h80;
  localparam logic [7:0] ADDR_PORT_ONE = 8'h90;
  localparam logic [7:0] ADDR_PORT_TWO = 8'hA0;

  // main page registers
  localparam logic [7:0] ADDR_P0_OUTPUT_MODE = 8'hA4;
  localparam logic [7:0] ADDR_P1_OUTPUT_MODE = 8'hA5;
  localparam logic [7:0] ADDR_P2_OUTPUT_MODE = 8'hA6;
  localparam logic [7:0] ADDR_P1_COMPARE_MASK = 8'hBF;
  localparam logic [7:0] ADDR_P0_COMPARE_MASK = 8'hC7;
  localparam logic [7:0] ADDR_P1_MATCH_VALUE = 8'hCF;
  localparam logic [7:0] ADDR_P0_CROSSBAR_SKIP = 8'hD4;
  localparam logic [7:0] ADDR_P1_CROSSBAR_SKIP = 8'hD5;
  localparam logic [7:0] ADDR_P0_MATCH_VALUE = 8'hD7;
  localparam logic [7:0] ADDR_CROSSBAR_SEL_ZERO = 8'hE1;
  localparam logic [7:0] ADDR_CROSSBAR_SEL_ONE = 8'hE2;
  localparam logic [7:0] ADDR_CROSSBAR_SEL_TWO = 8'hE3;
  localparam logic [7:0] ADDR_P0_INPUT_MODE = 8'hF1;
  localparam logic [7:0] ADDR_P1_INPUT_MODE = 8'hF2;

  // alternate page registers
  localparam logic [7:0] ADDR_P0_DRIVE_STRENGTH = 8'hA4;
  localparam logic [7:0] ADDR_P1_DRIVE_STRENGTH = 8'hA5;
  localparam logic [7:0] ADDR_P2_DRIVE_STRENGTH = 8'hA6;

  // field positions
  localparam int CROSSBAR_ENABLE_POS = 6;
  localparam int DIGITAL_ONLY_POS = 7;

  // values after reset
  localparam logic [7:0] RST_PORT_LATCH = 8'hFF;
  localparam logic [7:0] RST_MATCH_VALUE = 8'hFF;
  localparam logic [7:0] RST_COMPARE_MASK = 8'h00;
  localparam logic [7:0] RST_CROSSBAR_SKIP = 8'h00;
  localparam logic [7:0] RST_INPUT_MODE = 8'hFF;
  localparam logic [7:0] RST_OUTPUT_MODE = 8'h00;
  localparam logic [7:0] RST_DRIVE_STRENGTH = 8'h00;
  localparam logic [7:0] RST_CROSSBAR_SEL = 8'h00;
  localparam logic [7:0] RST_READ_DATA = 8'h00;

  // pin count: eight on port zero, eight on port one, one on port two
  localparam int PIN_COUNT = 17;

endpackage : port_io_pkg

// ---- port_io_with_pin_match.sv ----
// port_io_with_pin_match: port data latches, pin readback, pin configuration,
// pin driver control and port match for two 8-bit ports and one extra pin.
// assumes a single-cycle register bus on mclk; pins and crossbar signals
// arrive synchronous to mclk; read data appears one cycle after sfr_rd.
//
// How it works
// R1 - a mismatch event is raised when masked pins differ from masked match value
// R2 - mask bits pick compared pins; masked pins never cause a mismatch
// R3 - the mismatch event drives both an interrupt request and a wake request
// R4 - matching uses real pin levels, whatever the crossbar routes
// R5 - port data registers take byte writes and single-bit writes
// R6 - written port data is latched and keeps driving toward the pins
// R7 - ordinary port reads return pin levels, even for crossbar-owned pins
// R8 - read-modify-write reads return the latch, not the pins
// R9 - port data registers decode on every page
// R10 - skip bits exclude pins from crossbar assignment
// R11 - input mode bits select analog or digital, never changed automatically
// R12 - the top pin of port two is always digital, no analog selection
// R13 - output mode bits select open-drain or push-pull, never changed automatically
// R14 - two-wire bus data and clock pins are forced open-drain
// R15 - drive strength bits select high or low drive, low after reset
// R16 - all drivers stay off while the crossbar enable bit is clear
// R17 - mismatch is evaluated each clock from synchronised pins and held while differing
`timescale 1ns/1ns
`default_nettype none

module port_io_with_pin_match
  import port_io_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [3:0] sfr_page,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_bit_wr,
  input wire logic [2:0] sfr_bit_sel,
  input wire logic sfr_bit_val,
  input wire logic sfr_rd,
  input wire logic sfr_rmw,
  output logic [7:0] sfr_rdata,
  input wire logic [7:0] port_zero_pin_in,
  input wire logic [7:0] port_one_pin_in,
  input wire logic digital_only_pin_in,
  output logic [7:0] port_zero_pin_out,
  output logic [7:0] port_one_pin_out,
  output logic digital_only_pin_out,
  output logic [7:0] port_zero_pin_oe_n,
  output logic [7:0] port_one_pin_oe_n,
  output logic digital_only_pin_oe_n,
  output logic [7:0] port_zero_pin_high_drive,
  output logic [7:0] port_one_pin_high_drive,
  output logic digital_only_pin_high_drive,
  output logic [7:0] port_zero_pin_analog,
  output logic [7:0] port_one_pin_analog,
  input wire logic [16:0] xbar_pin_owned,
  input wire logic [16:0] xbar_pin_data,
  input wire logic [16:0] xbar_pin_two_wire,
  output logic [7:0] crossbar_pin_exclude_zero,
  output logic [7:0] crossbar_pin_exclude_one,
  output logic [7:0] crossbar_function_select_zero,
  output logic [7:0] crossbar_function_select_one,
  output logic [7:0] crossbar_function_select_two,
  output logic port_mismatch_irq,
  output logic port_mismatch_wake
);

  // configuration registers
  logic [7:0] port_zero_latch_reg, port_one_latch_reg, port_two_latch_reg;
  logic [7:0] p0_output_mode_reg, p1_output_mode_reg, p2_output_mode_reg;
  logic [7:0] p0_drive_reg, p1_drive_reg, p2_drive_reg;
  logic [7:0] p0_mask_reg, p1_mask_reg, p0_match_reg, p1_match_reg;
  logic [7:0] p0_skip_reg, p1_skip_reg, p0_input_mode_reg, p1_input_mode_reg;
  logic [7:0] crossbar_select_zero_reg, crossbar_select_one_reg, crossbar_select_two_reg, p0_analog_reg, p1_analog_reg;
  logic [7:0] rdata_next;

  // pin synchronisers
  logic [16:0] pin_meta_reg, pin_sync_reg;
  logic mismatch_reg;

  // page decode
  wire page_main = (sfr_page == PAGE_MAIN);
  wire page_alt = (sfr_page == PAGE_ALT);

  // port data decode on every page (see R9)
  wire sel_p0 = (sfr_addr == ADDR_PORT_ZERO);
  wire sel_p1 = (sfr_addr == ADDR_PORT_ONE);
  wire sel_p2 = (sfr_addr == ADDR_PORT_TWO);

  wire sel_p0_mdout = page_main && (sfr_addr == ADDR_P0_OUTPUT_MODE);
  wire sel_p1_mdout = page_main && (sfr_addr == ADDR_P1_OUTPUT_MODE);
  wire sel_p2_mdout = page_main && (sfr_addr == ADDR_P2_OUTPUT_MODE);
  wire sel_p0_drv = page_alt && (sfr_addr == ADDR_P0_DRIVE_STRENGTH);
  wire sel_p1_drv = page_alt && (sfr_addr == ADDR_P1_DRIVE_STRENGTH);
  wire sel_p2_drv = page_alt && (sfr_addr == ADDR_P2_DRIVE_STRENGTH);
  wire sel_p0_mask = page_main && (sfr_addr == ADDR_P0_COMPARE_MASK);
  wire sel_p1_mask = page_main && (sfr_addr == ADDR_P1_COMPARE_MASK);
  wire sel_p0_mat = page_main && (sfr_addr == ADDR_P0_MATCH_VALUE);
  wire sel_p1_mat = page_main && (sfr_addr == ADDR_P1_MATCH_VALUE);
  wire sel_p0_skip = page_main && (sfr_addr == ADDR_P0_CROSSBAR_SKIP);
  wire sel_p1_skip = page_main && (sfr_addr == ADDR_P1_CROSSBAR_SKIP);
  wire sel_crossbar_select_zero = page_main && (sfr_addr == ADDR_CROSSBAR_SEL_ZERO);
  wire sel_crossbar_select_one = page_main && (sfr_addr == ADDR_CROSSBAR_SEL_ONE);
  wire sel_crossbar_select_two = page_main && (sfr_addr == ADDR_CROSSBAR_SEL_TWO);
  wire sel_p0_mdin = page_main && (sfr_addr == ADDR_P0_INPUT_MODE);
  wire sel_p1_mdin = page_main && (sfr_addr == ADDR_P1_INPUT_MODE);

  // single-bit write sets or clears one latch bit, others kept (see R5)
  wire [7:0] bit_mask = 8'h01 << sfr_bit_sel;
  wire [7:0] bit_set = sfr_bit_val ? bit_mask : 8'h00;
  wire [7:0] p0_latch_next = sfr_wr ? sfr_wdata
                           : ((port_zero_latch_reg & ~bit_mask) | bit_set); // see R5
  wire [7:0] p1_latch_next = sfr_wr ? sfr_wdata
                           : ((port_one_latch_reg & ~bit_mask) | bit_set); // see R5
  wire [7:0] p2_latch_next = sfr_wr ? sfr_wdata
                           : ((port_two_latch_reg & ~bit_mask) | bit_set); // see R5
  wire port_wr = sfr_wr || sfr_bit_wr;

  // synchronised pin views
  wire [7:0] p0_pins = pin_sync_reg[7:0];
  wire [7:0] p1_pins = pin_sync_reg[15:8];
  wire [7:0] p2_pins = {pin_sync_reg[16], 7'h00};

  // port reads: pins normally, latch for read-modify-write (see R7, R8)
  wire [7:0] p0_read = sfr_rmw ? port_zero_latch_reg : p0_pins; // see R7 see R8
  wire [7:0] p1_read = sfr_rmw ? port_one_latch_reg : p1_pins; // see R7 see R8
  wire [7:0] p2_read = sfr_rmw ? port_two_latch_reg : p2_pins; // see R7 see R8

  // match comparison on real pin levels, masked per bit (see R1, R2, R4)
  wire [7:0] p0_diff = (p0_pins ^ p0_match_reg) & p0_mask_reg; // see R2 see R4
  wire [7:0] p1_diff = (p1_pins ^ p1_match_reg) & p1_mask_reg; // see R2 see R4
  wire mismatch_next = (|p0_diff) || (|p1_diff); // see R1 see R17

  // flattened per-pin configuration
  wire [16:0] latch_all = {port_two_latch_reg[DIGITAL_ONLY_POS], port_one_latch_reg,
                           port_zero_latch_reg};
  wire [16:0] push_pull_all = {p2_output_mode_reg[DIGITAL_ONLY_POS], p1_output_mode_reg,
                               p0_output_mode_reg};
  wire [16:0] drive_all = {p2_drive_reg[DIGITAL_ONLY_POS], p1_drive_reg, p0_drive_reg};
  wire [16:0] digital_all = {1'b1, p1_input_mode_reg, p0_input_mode_reg}; // see R12
  wire crossbar_on = crossbar_select_two_reg[CROSSBAR_ENABLE_POS];

  logic [16:0] pin_value_next, pin_oe_n_next, pin_high_next;
  logic [16:0] pin_value_reg, pin_oe_n_reg, pin_high_reg;

  genvar i;
  generate
    for (i = 0; i < PIN_COUNT; i++) begin : g_pin
      wire value = xbar_pin_owned[i] ? xbar_pin_data[i] : latch_all[i]; // see R6
      wire push_pull = push_pull_all[i] && !xbar_pin_two_wire[i]; // see R13 see R14
      wire drives = push_pull || !value;
      assign pin_value_next[i] = value;
      // drivers off with crossbar disabled or in analog mode (see R16, R11)
      assign pin_oe_n_next[i] = !(crossbar_on && digital_all[i] && drives); // see R16 see R11
      assign pin_high_next[i] = drive_all[i]; // see R15
    end
  endgenerate

  // read data select
  always_comb begin
    rdata_next = RST_READ_DATA;
    if (sel_p0) begin
      rdata_next = p0_read;
    end else if (sel_p1) begin
      rdata_next = p1_read;
    end else if (sel_p2) begin
      rdata_next = p2_read;
    end else if (sel_p0_mdout) begin
      rdata_next = p0_output_mode_reg;
    end else if (sel_p1_mdout) begin
      rdata_next = p1_output_mode_reg;
    end else if (sel_p2_mdout) begin
      rdata_next = p2_output_mode_reg;
    end else if (sel_p0_drv) begin
      rdata_next = p0_drive_reg;
    end else if (sel_p1_drv) begin
      rdata_next = p1_drive_reg;
    end else if (sel_p2_drv) begin
      rdata_next = p2_drive_reg;
    end else if (sel_p0_mask) begin
      rdata_next = p0_mask_reg;
    end else if (sel_p1_mask) begin
      rdata_next = p1_mask_reg;
    end else if (sel_p0_mat) begin
      rdata_next = p0_match_reg;
    end else if (sel_p1_mat) begin
      rdata_next = p1_match_reg;
    end else if (sel_p0_skip) begin
      rdata_next = p0_skip_reg;
    end else if (sel_p1_skip) begin
      rdata_next = p1_skip_reg;
    end else if (sel_crossbar_select_zero) begin
      rdata_next = crossbar_select_zero_reg;
    end else if (sel_crossbar_select_one) begin
      rdata_next = crossbar_select_one_reg;
    end else if (sel_crossbar_select_two) begin
      rdata_next = crossbar_select_two_reg;
    end else if (sel_p0_mdin) begin
      rdata_next = p0_input_mode_reg;
    end else if (sel_p1_mdin) begin
      rdata_next = p1_input_mode_reg;
    end
  end

  // port output latches
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      port_zero_latch_reg <= RST_PORT_LATCH;
      port_one_latch_reg <= RST_PORT_LATCH;
      port_two_latch_reg <= RST_PORT_LATCH;
    end else begin
      if (port_wr && sel_p0) port_zero_latch_reg <= p0_latch_next; // see R6 see R9
      if (port_wr && sel_p1) port_one_latch_reg <= p1_latch_next; // see R6 see R9
      if (port_wr && sel_p2) port_two_latch_reg <= p2_latch_next; // see R6 see R9
    end
  end

  // output mode and drive strength
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      p0_output_mode_reg <= RST_OUTPUT_MODE;
      p1_output_mode_reg <= RST_OUTPUT_MODE;
      p2_output_mode_reg <= RST_OUTPUT_MODE;
      p0_drive_reg <= RST_DRIVE_STRENGTH;
      p1_drive_reg <= RST_DRIVE_STRENGTH;
      p2_drive_reg <= RST_DRIVE_STRENGTH;
    end else if (sfr_wr) begin
      if (sel_p0_mdout) p0_output_mode_reg <= sfr_wdata; // see R13
      if (sel_p1_mdout) p1_output_mode_reg <= sfr_wdata; // see R13
      if (sel_p2_mdout) p2_output_mode_reg <= sfr_wdata; // see R13
      if (sel_p0_drv) p0_drive_reg <= sfr_wdata; // see R15
      if (sel_p1_drv) p1_drive_reg <= sfr_wdata; // see R15
      if (sel_p2_drv) p2_drive_reg <= sfr_wdata; // see R15
    end
  end

  // match, mask, skip, input mode and crossbar selection
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      p0_mask_reg <= RST_COMPARE_MASK;
      p1_mask_reg <= RST_COMPARE_MASK;
      p0_match_reg <= RST_MATCH_VALUE;
      p1_match_reg <= RST_MATCH_VALUE;
      p0_skip_reg <= RST_CROSSBAR_SKIP;
      p1_skip_reg <= RST_CROSSBAR_SKIP;
      p0_input_mode_reg <= RST_INPUT_MODE;
      p1_input_mode_reg <= RST_INPUT_MODE;
      crossbar_select_zero_reg <= RST_CROSSBAR_SEL;
      crossbar_select_one_reg <= RST_CROSSBAR_SEL;
      crossbar_select_two_reg <= RST_CROSSBAR_SEL;
    end else if (sfr_wr) begin
      if (sel_p0_mask) p0_mask_reg <= sfr_wdata; // see R2
      if (sel_p1_mask) p1_mask_reg <= sfr_wdata; // see R2
      if (sel_p0_mat) p0_match_reg <= sfr_wdata;
      if (sel_p1_mat) p1_match_reg <= sfr_wdata;
      if (sel_p0_skip) p0_skip_reg <= sfr_wdata; // see R10
      if (sel_p1_skip) p1_skip_reg <= sfr_wdata; // see R10
      if (sel_p0_mdin) p0_input_mode_reg <= sfr_wdata; // see R11
      if (sel_p1_mdin) p1_input_mode_reg <= sfr_wdata; // see R11
      if (sel_crossbar_select_zero) crossbar_select_zero_reg <= sfr_wdata;
      if (sel_crossbar_select_one) crossbar_select_one_reg <= sfr_wdata;
      if (sel_crossbar_select_two) crossbar_select_two_reg <= sfr_wdata; // see R16
    end
  end

  // read data
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= RST_READ_DATA;
    end else if (sfr_rd) begin
      sfr_rdata <= rdata_next;
    end
  end

  // pin synchroniser and mismatch (see R17)
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      mismatch_reg <= 1'b0;
    end else begin
      pin_meta_reg <= {digital_only_pin_in, port_one_pin_in, port_zero_pin_in}; // see R4
      pin_sync_reg <= pin_meta_reg;
      mismatch_reg <= mismatch_next; // see R17
    end
  end

  // registered pin controls
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_value_reg <= '1;
      pin_oe_n_reg <= '1;
      pin_high_reg <= '0;
      p0_analog_reg <= ~RST_INPUT_MODE;
      p1_analog_reg <= ~RST_INPUT_MODE;
    end else begin
      pin_value_reg <= pin_value_next;
      p0_analog_reg <= ~p0_input_mode_reg; // see R11
      p1_analog_reg <= ~p1_input_mode_reg; // see R11
      pin_oe_n_reg <= pin_oe_n_next; // see R16
      pin_high_reg <= pin_high_next; // see R15
    end
  end

  assign port_zero_pin_out = pin_value_reg[7:0];
  assign port_one_pin_out = pin_value_reg[15:8];
  assign digital_only_pin_out = pin_value_reg[16];
  assign port_zero_pin_oe_n = pin_oe_n_reg[7:0];
  assign port_one_pin_oe_n = pin_oe_n_reg[15:8];
  assign digital_only_pin_oe_n = pin_oe_n_reg[16];
  assign port_zero_pin_high_drive = pin_high_reg[7:0];
  assign port_one_pin_high_drive = pin_high_reg[15:8];
  assign digital_only_pin_high_drive = pin_high_reg[16];
  assign port_zero_pin_analog = p0_analog_reg; // see R11
  assign port_one_pin_analog = p1_analog_reg; // see R11
  assign crossbar_pin_exclude_zero = p0_skip_reg; // see R10
  assign crossbar_pin_exclude_one = p1_skip_reg; // see R10
  assign crossbar_function_select_zero = crossbar_select_zero_reg;
  assign crossbar_function_select_one = crossbar_select_one_reg;
  assign crossbar_function_select_two = crossbar_select_two_reg;
  assign port_mismatch_irq = mismatch_reg; // see R3
  assign port_mismatch_wake = mismatch_reg; // see R3

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_mismatch_from_pins;
    1'b1 |=> mismatch_reg == $past(((p0_pins & p0_mask_reg) != (p0_match_reg & p0_mask_reg))
      || ((p1_pins & p1_mask_reg) != (p1_match_reg & p1_mask_reg)));
  endproperty
  a_mismatch_from_pins: assert property (p_mismatch_from_pins) // see R1
    else $error("mismatch does not follow masked pin compare");
  property p_masked_quiet;
    (p0_mask_reg == 8'h00 && p1_mask_reg == 8'h00) ##1
      (p0_mask_reg == 8'h00 && p1_mask_reg == 8'h00) |-> !mismatch_reg;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) // see R2
    else $error("mismatch with all pins masked");
  property p_irq_wake_pair;
    port_mismatch_irq == port_mismatch_wake;
  endproperty
  a_irq_wake_pair: assert property (p_irq_wake_pair) // see R3
    else $error("interrupt and wake requests differ");
  property p_pin_to_mismatch;
    (p0_mask_reg[0] && p0_match_reg[0] != port_zero_pin_in[0] && !sfr_wr)
      ##1 (!sfr_wr && p0_match_reg[0] != port_zero_pin_in[0])
      ##1 !sfr_wr |-> ##1 mismatch_reg;
  endproperty
  a_pin_to_mismatch: assert property (p_pin_to_mismatch) // see R4
    else $error("pin differing from match did not raise mismatch");
  property p_read_pins;
    sfr_rd && !sfr_rmw && sel_p1 |=> sfr_rdata == $past(pin_sync_reg[15:8]);
  endproperty
  a_read_pins: assert property (p_read_pins) // see R7
    else $error("port read did not return pin levels");
  property p_read_latch;
    sfr_rd && sfr_rmw && sel_p0 |=> sfr_rdata == $past(port_zero_latch_reg);
  endproperty
  a_read_latch: assert property (p_read_latch) // see R8
    else $error("read-modify-write read did not return latch");
  property p_bit_write;
    sfr_bit_wr && !sfr_wr && sel_p1 |=>
      port_one_latch_reg[$past(sfr_bit_sel)] == $past(sfr_bit_val);
  endproperty
  a_bit_write: assert property (p_bit_write) // see R5
    else $error("bit write did not reach latch");
  property p_any_page;
    sfr_wr && sel_p2 && sfr_page != PAGE_MAIN |=> port_two_latch_reg == $past(sfr_wdata);
  endproperty
  a_any_page: assert property (p_any_page) // see R9
    else $error("port data write lost on another page");
  property p_drivers_off;
    !crossbar_on |=> pin_oe_n_reg == '1;
  endproperty
  a_drivers_off: assert property (p_drivers_off) // see R16
    else $error("driver enabled with crossbar off");
  property p_two_wire_open_drain;
    xbar_pin_two_wire[0] && xbar_pin_owned[0] && xbar_pin_data[0] |=> pin_oe_n_reg[0];
  endproperty
  a_two_wire_open_drain: assert property (p_two_wire_open_drain) // see R14
    else $error("two-wire pin driven high");
  property p_drive_strength;
    sfr_wr && sel_p1_drv |=> ##1 port_one_pin_high_drive == $past(sfr_wdata, 2);
  endproperty
  a_drive_strength: assert property (p_drive_strength) // see R15
    else $error("drive strength not applied");
  property p_digital_only;
    crossbar_on && !xbar_pin_owned[16] && !port_two_latch_reg[DIGITAL_ONLY_POS]
      |=> !digital_only_pin_oe_n;
  endproperty
  a_digital_only: assert property (p_digital_only) // see R12
    else $error("digital-only pin not driving low");
  c_mismatch_rise: cover property ($rose(mismatch_reg));
  c_mismatch_clear: cover property ($fell(mismatch_reg));
  c_rmw_read: cover property (sfr_rd && sfr_rmw && sel_p0);
  c_bit_write: cover property (sfr_bit_wr && sel_p1);

endmodule : port_io_with_pin_match

`default_nettype wire

// ---- pin_world.sv ----
// pin_world: the pins as seen from outside the port block
// assumes the resolved level feeds the block's pin inputs directly
`timescale 1ns/1ns
`default_nettype none

module pin_world (
  input wire logic [16:0] pin_out,
  input wire logic [16:0] pin_oe_n,
  input wire logic [16:0] ext_drive,
  input wire logic [16:0] ext_en,
  output logic [16:0] pin_level
);
  // block driver wins; undriven pins take ext_drive where ext_en is set, else fall to the external pull-up
  assign pin_level = (~pin_oe_n & pin_out) |
    (pin_oe_n & ((ext_en & ext_drive) | ~ext_en));
endmodule : pin_world

`default_nettype wire

// ---- tb_port_io_with_pin_match.sv ----
// tb_port_io_with_pin_match: random and corner tests of the port block
// assumes pin_world resolves the pins; reads answer one cycle after sfr_rd
`timescale 1ns/1ns
`default_nettype none

module tb_port_io_with_pin_match;
  import port_io_pkg::*;
  logic mclk, rst_n, sfr_wr, sfr_bit_wr, sfr_bit_val, sfr_rd, sfr_rmw;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, d, rl, rm, rk, rp, rq, rs, rs1, xs0, xs1, xs2;
  logic [3:0] sfr_page;
  logic [2:0] sfr_bit_sel;
  logic [7:0] p0_out, p1_out, p0_oe_n, p1_oe_n, p0_hd, p1_hd, p0_an, p1_an;
  logic dop_out, dop_oe_n, dop_hd, irq, wake;
  logic [16:0] owned, xdata, two_wire, ext_drive, level;
  int err_count, compares;
  logic [7:0] seed;

  always #4 mclk = ~mclk;

  port_io_with_pin_match dut_u (.mclk(mclk), .rst_n(rst_n), .sfr_addr(sfr_addr),
    .sfr_page(sfr_page), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr),
    .sfr_bit_sel(sfr_bit_sel), .sfr_bit_val(sfr_bit_val), .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw),
    .sfr_rdata(sfr_rdata), .port_zero_pin_in(level[7:0]), .port_one_pin_in(level[15:8]),
    .digital_only_pin_in(level[16]), .port_zero_pin_out(p0_out), .port_one_pin_out(p1_out),
    .digital_only_pin_out(dop_out), .port_zero_pin_oe_n(p0_oe_n), .port_one_pin_oe_n(p1_oe_n),
    .digital_only_pin_oe_n(dop_oe_n), .port_zero_pin_high_drive(p0_hd),
    .port_one_pin_high_drive(p1_hd), .digital_only_pin_high_drive(dop_hd),
    .port_zero_pin_analog(p0_an), .port_one_pin_analog(p1_an), .xbar_pin_owned(owned),
    .xbar_pin_data(xdata), .xbar_pin_two_wire(two_wire), .crossbar_pin_exclude_zero(rs),
    .crossbar_pin_exclude_one(rs1), .crossbar_function_select_zero(xs0),
    .crossbar_function_select_one(xs1), .crossbar_function_select_two(xs2),
    .port_mismatch_irq(irq), .port_mismatch_wake(wake));

  pin_world world_u (.pin_out({dop_out, p1_out, p0_out}),
    .pin_oe_n({dop_oe_n, p1_oe_n, p0_oe_n}), .ext_drive(ext_drive), .ext_en(17'h1FFFF),
    .pin_level(level));

  function logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  function logic [7:0] mis(input logic [7:0] p0, m0, k0, p1, m1, k1);
    return {7'h00, ((p0 & k0) != (m0 & k0)) || ((p1 & k1) != (m1 & k1))};
  endfunction : mis

  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task wr(input logic [3:0] pg, input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    sfr_page <= pg; sfr_addr <= a; sfr_wdata <= v; sfr_wr <= 1'h1;
    @(posedge mclk);
    sfr_wr <= 1'h0;
  endtask : wr

  task rd(input logic [3:0] pg, input logic [7:0] a, input logic m);
    @(posedge mclk);
    sfr_page <= pg; sfr_addr <= a; sfr_rmw <= m; sfr_rd <= 1'h1;
    @(posedge mclk);
    sfr_rd <= 1'h0;
    #1 d = sfr_rdata;
  endtask : rd

  task rnd(output logic [7:0] v);
    seed = lfsr(seed);
    v = seed;
  endtask : rnd

  task give_verdict;
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  initial begin
    mclk = 0; rst_n = 0; sfr_wr = 0; sfr_bit_wr = 0; sfr_bit_val = 0; sfr_rd = 0;
    sfr_rmw = 0; sfr_addr = 8'h00; sfr_wdata = 8'h00; sfr_page = 4'h0; sfr_bit_sel = 3'h0;
    owned = 17'h00000; xdata = 17'h00000; two_wire = 17'h00000; ext_drive = 17'h1FFFF;
    err_count = 0; compares = 0; seed = 8'h32;
    repeat (4) @(posedge mclk);
    rst_n <= 1'h1;
    #1 check("oe_n", p0_oe_n & p1_oe_n, 8'hFF);
    check("high drive", p0_hd | p1_hd, 8'h00);
    check("analog", p0_an | p1_an, 8'h00);
    rd(PAGE_MAIN, ADDR_P0_MATCH_VALUE, 1'h0); check("match", d, RST_MATCH_VALUE);
    rd(PAGE_ALT, ADDR_P0_DRIVE_STRENGTH, 1'h0); check("drive reg", d, 8'h00);
    for (int i = 0; i < 8; i++) begin
      rnd(rl); rnd(rp);
      wr(i[0] ? PAGE_ALT : PAGE_MAIN, ADDR_PORT_ZERO, rl);
      ext_drive[7:0] <= rp;
      repeat (3) @(posedge mclk);
      rd(PAGE_ALT, ADDR_PORT_ZERO, 1'h1); check("latch", d, rl);
      rd(PAGE_MAIN, ADDR_PORT_ZERO, 1'h0); check("pins", d, rp);
    end
    wr(PAGE_MAIN, ADDR_PORT_ONE, 8'hFF);
    @(posedge mclk);
    sfr_addr <= ADDR_PORT_ONE; sfr_bit_sel <= 3'h3; sfr_bit_val <= 1'h0; sfr_bit_wr <= 1'h1;
    @(posedge mclk);
    sfr_bit_wr <= 1'h0;
    rd(PAGE_MAIN, ADDR_PORT_ONE, 1'h1); check("bit write", d, 8'hF7);
    rd(PAGE_MAIN, 8'h81, 1'h0); check("unmapped", d, 8'h00);
    rd(PAGE_ALT, ADDR_P0_MATCH_VALUE, 1'h0); check("wrong page", d, 8'h00);
    for (int i = 0; i < 12; i++) begin
      rnd(rm); rnd(rk); rnd(rp); rnd(rq); rnd(rl);
      if (i == 0) rk = 8'h00;
      wr(PAGE_MAIN, ADDR_P0_COMPARE_MASK, rk);
      wr(PAGE_MAIN, ADDR_P1_COMPARE_MASK, ~rk);
      wr(PAGE_MAIN, ADDR_P0_MATCH_VALUE, rm);
      wr(PAGE_MAIN, ADDR_P1_MATCH_VALUE, rl);
      ext_drive[15:0] <= {rq, rp};
      owned <= {rl[0], rq, rm};
      repeat (4) @(posedge mclk);
      #1 check("mismatch", {7'h00, irq}, mis(rp, rm, rk, rq, rl, ~rk));
      check("wake", {7'h00, wake}, {7'h00, irq});
    end
    owned <= 17'h00000;
    rnd(rk);
    wr(PAGE_MAIN, ADDR_P0_CROSSBAR_SKIP, rk);
    wr(PAGE_MAIN, ADDR_P1_CROSSBAR_SKIP, ~rk);
    wr(PAGE_MAIN, ADDR_CROSSBAR_SEL_ZERO, rk);
    wr(PAGE_MAIN, ADDR_CROSSBAR_SEL_ONE, ~rk);
    wr(PAGE_MAIN, ADDR_P0_INPUT_MODE, 8'h0F);
    wr(PAGE_ALT, ADDR_P0_DRIVE_STRENGTH, rk);
    repeat (2) @(posedge mclk);
    #1 check("skip", rs, rk);
    check("analog", p0_an, 8'hF0);
    check("high drive", p0_hd, rk);
    check("skip one", rs1, ~rk);
    check("xbar zero", xs0, rk);
    check("xbar one", xs1, ~rk);
    wr(PAGE_MAIN, ADDR_P0_INPUT_MODE, 8'hFF);
    wr(PAGE_MAIN, ADDR_P0_OUTPUT_MODE, 8'hFF);
    wr(PAGE_MAIN, ADDR_PORT_ZERO, 8'hA5);
    repeat (3) @(posedge mclk);
    #1 check("off drivers", p0_oe_n, 8'hFF);
    wr(PAGE_MAIN, ADDR_CROSSBAR_SEL_TWO, 8'h40);
    repeat (3) @(posedge mclk);
    #1 check("push pull", p0_oe_n, 8'h00);
    check("xbar two", xs2, 8'h40);
    check("pin out", p0_out, 8'hA5);
    wr(PAGE_MAIN, ADDR_P0_OUTPUT_MODE, 8'h00);
    repeat (3) @(posedge mclk);
    #1 check("open drain", p0_oe_n, 8'hA5);
    wr(PAGE_MAIN, ADDR_P0_OUTPUT_MODE, 8'hFF);
    two_wire <= 17'h000FF;
    owned <= 17'h000FF;
    xdata <= 17'h000A5;
    repeat (3) @(posedge mclk);
    #1 check("two wire", p0_oe_n, 8'hA5);
    check("port one oe", p1_oe_n, 8'hF7);
    check("port one out", p1_out, 8'hF7);
    check("digital pin", {5'h00, dop_out, dop_oe_n, dop_hd}, 8'h06);
    rd(PAGE_MAIN, ADDR_PORT_TWO, 1'h0); check("port two pins", d, 8'h80);
    wr(PAGE_MAIN, ADDR_PORT_TWO, 8'h00);
    repeat (3) @(posedge mclk);
    #1 check("digital drive", {6'h00, dop_out, dop_oe_n}, 8'h00);
    give_verdict();
  end
endmodule : tb_port_io_with_pin_match

`default_nettype wire
